// ---- hw/pef_event_flags.v ----
// Contract
// - Subaddress zero reads part code in bits 7-3, silicon step in 2-0.
// - First event register at subaddress one, resets zero, bits 7-6 read zero.
// - Bit 5 sets when input voltage is too low for programming defaults.
// - Bit 4 sets on any adapter-detect input edge, rising or falling.
// - Bit 3 sets on any push-button input edge, rising or falling.
// - Bit 2 sets above warning threshold, clears on read once temperature is below.
// - Bit 1 sets when backup-cell comparators settle and results are readable.
// - Bit 0 sets when nonvolatile default programming completes successfully.
// - Second event register at subaddress two, resets zero, bits 7-6 read zero.
// - Bits 5 and 3 set on third and first switch thermal fault.
// - Bit 4 sets on second switch thermal fault.
// - Bits 2-0 set while third, second, first switch limits current.
// - Unmasked event pulls interrupt low; masked event leaves interrupt alone.
// - Mask gates only the interrupt; flags keep recording regardless.
`timescale 1ns/100ps
`default_nettype none
`include "pef_map.vh"

module pef_event_flags #(
   parameter [4:0] PART_CODE    = 5'h1e, // Arbitrary value
   parameter [2:0] SILICON_STEP = 3'h2   // Arbitrary value
) (
   // Clock and reset
   input  wire       ref_clk,
   input  wire       resetn,
   // Register access from the serial bus engine
   input  wire       reg_rd_en,
   input  wire       reg_wr_en,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wr_data,
   output reg  [7:0] reg_rd_data,
   output reg        reg_rd_valid,
   // Raw system conditions
   input  wire       programming_voltage_low,
   input  wire       adapter_detect_input,
   input  wire       button_input,
   input  wire       overtemp_warning,
   input  wire       backup_cell_sample_done,
   input  wire       defaults_burn_done,
   // Raw load switch conditions
   input  wire       switch3_fault,
   input  wire       switch2_fault,
   input  wire       switch1_fault,
   input  wire       switch3_current_limit,
   input  wire       switch2_current_limit,
   input  wire       switch1_current_limit,
   // Interrupt pin
   output reg        irq_out_n
);

   function is_addr;
      input [7:0] addr;
      input [7:0] target;
      begin
         is_addr = (addr == target);
      end
   endfunction

   // Reserved bits 7-6 of every six-bit register read as zero
   function [7:0] pad_field;
      input [`PEF_FLAG_W-1:0] field;
      begin
         pad_field = {2'b00, field};
      end
   endfunction

   reg  [`PEF_FLAG_W-1:0] system_event_flags;
   reg  [`PEF_FLAG_W-1:0] switch_event_flags;
   reg  [`PEF_FLAG_W-1:0] system_mask;
   reg  [`PEF_FLAG_W-1:0] switch_mask;
   reg                    adapter_prev;
   reg                    button_prev;
   reg                    prev_valid;

   reg  [`PEF_FLAG_W-1:0] system_set;
   reg  [`PEF_FLAG_W-1:0] switch_set;
   wire [`PEF_FLAG_W-1:0] next_system_event_flags;
   wire [`PEF_FLAG_W-1:0] next_switch_event_flags;
   wire [`PEF_FLAG_W-1:0] system_pending;
   wire [`PEF_FLAG_W-1:0] switch_pending;
   reg  [`PEF_FLAG_W-1:0] next_system_mask;
   reg  [`PEF_FLAG_W-1:0] next_switch_mask;
   reg  [7:0]             next_rd_data;

   wire rd_system = reg_rd_en & is_addr(reg_addr, `PEF_ADDR_SYSTEM_EVENTS);
   wire rd_switch = reg_rd_en & is_addr(reg_addr, `PEF_ADDR_SWITCH_EVENTS);

   // Event set terms
   always @* begin
      system_set = `PEF_FLAG_RESET;
      switch_set = `PEF_FLAG_RESET;
      system_set[`PEF_BIT_PROG_VOLT_LOW] = programming_voltage_low;
      system_set[`PEF_BIT_ADAPTER_CHANGE] =
         prev_valid & (adapter_detect_input ^ adapter_prev);
      system_set[`PEF_BIT_BUTTON_CHANGE] =
         prev_valid & (button_input ^ button_prev);
      system_set[`PEF_BIT_OVERTEMP] = overtemp_warning;
      system_set[`PEF_BIT_CELL_DONE] = backup_cell_sample_done;
      system_set[`PEF_BIT_BURN_DONE] = defaults_burn_done;
      switch_set[`PEF_BIT_SW3_FAULT] = switch3_fault;
      switch_set[`PEF_BIT_SW1_FAULT] = switch1_fault;
      switch_set[`PEF_BIT_SW2_FAULT] = switch2_fault;
      switch_set[`PEF_BIT_SW3_LIMIT] = switch3_current_limit;
      switch_set[`PEF_BIT_SW2_LIMIT] = switch2_current_limit;
      switch_set[`PEF_BIT_SW1_LIMIT] = switch1_current_limit;
   end

   // Sticky flags: set beats clear-on-read; level sources re-set while held
   genvar bit_idx;
   generate
      for (bit_idx = 0; bit_idx < `PEF_FLAG_W; bit_idx = bit_idx + 1) begin : g_flag
         assign next_system_event_flags[bit_idx] =
            system_set[bit_idx] | (system_event_flags[bit_idx] & ~rd_system);
         assign next_switch_event_flags[bit_idx] =
            switch_set[bit_idx] | (switch_event_flags[bit_idx] & ~rd_switch);
         // Mask gates only the interrupt path, never the flag itself
         assign system_pending[bit_idx] =
            next_system_event_flags[bit_idx] & ~next_system_mask[bit_idx];
         assign switch_pending[bit_idx] =
            next_switch_event_flags[bit_idx] & ~next_switch_mask[bit_idx];
      end
   endgenerate

   // Mask writes land at the next edge; other subaddresses are read-only
   always @* begin
      next_system_mask = system_mask;
      next_switch_mask = switch_mask;
      if (reg_wr_en && is_addr(reg_addr, `PEF_ADDR_SYSTEM_MASK)) begin
         next_system_mask = reg_wr_data[`PEF_FLAG_W-1:0];
      end
      if (reg_wr_en && is_addr(reg_addr, `PEF_ADDR_SWITCH_MASK)) begin
         next_switch_mask = reg_wr_data[`PEF_FLAG_W-1:0];
      end
   end

   // Read mux; reserved bits 7-6 and unmapped addresses read zero
   always @* begin
      next_rd_data = `PEF_DATA_RESET;
      case (reg_addr)
         `PEF_ADDR_PART_IDENTITY: begin
            next_rd_data = {PART_CODE, SILICON_STEP};
         end
         `PEF_ADDR_SYSTEM_EVENTS: begin
            next_rd_data = pad_field(system_event_flags);
         end
         `PEF_ADDR_SWITCH_EVENTS: begin
            next_rd_data = pad_field(switch_event_flags);
         end
         `PEF_ADDR_SYSTEM_MASK: begin
            next_rd_data = pad_field(system_mask);
         end
         `PEF_ADDR_SWITCH_MASK: begin
            next_rd_data = pad_field(switch_mask);
         end
         default: begin
            next_rd_data = `PEF_DATA_RESET;
         end
      endcase
   end

   // First edge after reset only captures pin levels, so no false change
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         adapter_prev <= 1'b0;
         button_prev  <= 1'b0;
         prev_valid   <= 1'b0;
      end else begin
         // Edge detectors compare against the level one edge earlier
         adapter_prev <= adapter_detect_input;
         button_prev  <= button_input;
         prev_valid   <= 1'b1;
      end
   end

   // Flags record regardless of what the masks say
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         system_event_flags <= `PEF_FLAG_RESET;
         switch_event_flags <= `PEF_FLAG_RESET;
      end else begin
         system_event_flags <= next_system_event_flags;
         switch_event_flags <= next_switch_event_flags;
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         system_mask <= `PEF_MASK_RESET;
         switch_mask <= `PEF_MASK_RESET;
      end else begin
         system_mask <= next_system_mask;
         switch_mask <= next_switch_mask;
      end
   end

   // Read data holds until the next read strobe
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rd_data  <= `PEF_DATA_RESET;
         reg_rd_valid <= 1'b0;
      end else begin
         // Valid pulses one cycle after each read strobe
         reg_rd_valid <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rd_data <= next_rd_data;
         end
      end
   end

   // Interrupt follows the next flags and masks, so it moves with them
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_out_n <= 1'b1;
      end else begin
         irq_out_n <= ~((|system_pending) | (|switch_pending));
      end
   end

endmodule
`default_nettype wire

// ---- hw/pef_map.vh ----
`ifndef PEF_MAP_VH
`define PEF_MAP_VH

// Register subaddresses
`define PEF_ADDR_PART_IDENTITY 8'h00
`define PEF_ADDR_SYSTEM_EVENTS 8'h01
`define PEF_ADDR_SWITCH_EVENTS 8'h02
`define PEF_ADDR_SYSTEM_MASK   8'h03
`define PEF_ADDR_SWITCH_MASK   8'h04

// Identity fields
`define PEF_PART_MSB 7
`define PEF_PART_LSB 3
`define PEF_STEP_MSB 2
`define PEF_STEP_LSB 0

// System event flag positions
`define PEF_BIT_PROG_VOLT_LOW  5
`define PEF_BIT_ADAPTER_CHANGE 4
`define PEF_BIT_BUTTON_CHANGE  3
`define PEF_BIT_OVERTEMP       2
`define PEF_BIT_CELL_DONE      1
`define PEF_BIT_BURN_DONE      0

// Switch event flag positions
`define PEF_BIT_SW3_FAULT 5
`define PEF_BIT_SW2_FAULT 4
`define PEF_BIT_SW1_FAULT 3
`define PEF_BIT_SW3_LIMIT 2
`define PEF_BIT_SW2_LIMIT 1
`define PEF_BIT_SW1_LIMIT 0

// Field widths and reset values
`define PEF_FLAG_W      6
`define PEF_FLAG_RESET  6'h00
`define PEF_MASK_RESET  6'h00
`define PEF_DATA_RESET  8'h00

`endif

// ---- tb/pef_chk_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module pef_chk (
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic       reg_rd_en,
   input wire logic       reg_wr_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rd_data,
   input wire logic       reg_rd_valid,
   input wire logic       irq_out_n,
   input wire logic       button_input,
   input wire logic       overtemp_warning,
   input wire logic       switch1_current_limit
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   AST_RDV: assert property (reg_rd_en |=> reg_rd_valid) else $error("no valid");
   AST_IDLE: assert property (!reg_rd_en |=> !reg_rd_valid) else $error("stray valid");
   AST_RSV1: assert property (reg_rd_en && reg_addr == 8'h01 |=> reg_rd_data[7:6] == 2'b00)
      else $error("reserved set");
   AST_RSV2: assert property (reg_rd_en && reg_addr == 8'h02 |=> reg_rd_data[7:6] == 2'b00)
      else $error("reserved set");
   AST_OVERTEMP: assert property (overtemp_warning ##1 (reg_rd_en && reg_addr == 8'h01)
      |=> reg_rd_data[2]) else $error("overtemp flag lost");
   AST_LIM: assert property (switch1_current_limit ##1 (reg_rd_en && reg_addr == 8'h02)
      |=> reg_rd_data[0]) else $error("limit lost");
   AST_BTN: assert property ($changed(button_input) ##1 (reg_rd_en && reg_addr == 8'h01)
      |=> reg_rd_data[3]) else $error("button lost");
   AST_HOLD: assert property (!irq_out_n && !reg_rd_en && !reg_wr_en |=> !irq_out_n)
      else $error("irq dropped");
   AST_RD_HOLD: assert property (!reg_rd_en |=> $stable(reg_rd_data))
      else $error("read data moved");
endmodule
bind pef_event_flags pef_chk u_chk (.ref_clk, .resetn, .reg_rd_en, .reg_wr_en, .reg_addr,
   .reg_rd_data, .reg_rd_valid, .irq_out_n, .button_input, .overtemp_warning,
   .switch1_current_limit);
`default_nettype wire

// ---- tb/pef_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module pef_host (
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rd_data,
   input  wire logic       reg_rd_valid,
   output var  logic       reg_rd_en,
   output var  logic       reg_wr_en,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wr_data
);
   initial begin
      reg_rd_en = 1'b0;
      reg_wr_en = 1'b0;
      reg_addr = 8'hff;
      reg_wr_data = 8'h00;
   end
   // One strobe cycle, answer one cycle later, then scrambled bus
   task automatic acc(input logic w, input logic [7:0] a, d, output logic v,
                      output logic [7:0] q);
      @(negedge ref_clk);
      reg_rd_en = !w;
      reg_wr_en = w;
      reg_addr = a;
      reg_wr_data = d;
      @(negedge ref_clk);
      reg_rd_en = 1'b0;
      reg_wr_en = 1'b0;
      reg_addr = ~a;
      reg_wr_data = ~d;
      v = reg_rd_valid;
      q = reg_rd_data;
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_pef_event_flags.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
   $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_pef_event_flags;
   localparam logic [7:0] ID = 8'h5b; // Arbitrary value
   logic ref_clk, resetn, rd_en, wr_en, rv, irq_n, v;
   logic [5:0] sy, sw;
   logic [7:0] addr, wdat, rdat, q;
   int n_mismatch = 0, n_compared = 0;
   pef_host host (.ref_clk, .reg_rd_data(rdat), .reg_rd_valid(rv), .reg_rd_en(rd_en),
      .reg_wr_en(wr_en), .reg_addr(addr), .reg_wr_data(wdat));
   pef_event_flags #(.PART_CODE(ID[7:3]), .SILICON_STEP(ID[2:0])) dut (.ref_clk, .resetn,
      .reg_rd_en(rd_en), .reg_wr_en(wr_en), .reg_addr(addr), .reg_wr_data(wdat),
      .reg_rd_data(rdat), .reg_rd_valid(rv), .programming_voltage_low(sy[5]),
      .adapter_detect_input(sy[4]), .button_input(sy[3]), .overtemp_warning(sy[2]),
      .backup_cell_sample_done(sy[1]), .defaults_burn_done(sy[0]), .switch3_fault(sw[5]),
      .switch2_fault(sw[4]), .switch1_fault(sw[3]), .switch3_current_limit(sw[2]),
      .switch2_current_limit(sw[1]), .switch1_current_limit(sw[0]), .irq_out_n(irq_n));
   task automatic rd(input logic [7:0] a, e);
      host.acc(1'b0, a, 8'h00, v, q);
      `CHK(v, 1'b1)
      `CHK(q, e)
   endtask
   // Toggle for one cycle; pin inputs keep their new level
   task automatic pulse(input logic [5:0] s, w);
      @(negedge ref_clk);
      sy = sy ^ s;
      sw = sw ^ w;
      @(negedge ref_clk);
      sy = sy ^ (s & 6'h27);
      sw = sw ^ w;
   endtask
   task automatic t_reset;
      rd(8'h00, ID);
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h00);
   endtask
   task automatic t_event(input logic [7:0] a, input logic [5:0] s, w);
      pulse(s, w);
      `CHK(irq_n, 1'b0)
      rd(a, 8'h3f);
      rd(a, 8'h00);
      `CHK(irq_n, 1'b1)
   endtask
   task automatic t_mask;
      host.acc(1'b1, 8'h03, 8'h3f, v, q);
      `CHK(v, 1'b0)
      host.acc(1'b1, 8'h04, 8'h3f, v, q);
      host.acc(1'b1, 8'h01, 8'hff, v, q);
      rd(8'h03, 8'h3f);
      rd(8'h04, 8'h3f);
      pulse(6'h18, 6'h3f);
      `CHK(irq_n, 1'b1)
      rd(8'h01, 8'h18);
      rd(8'h02, 8'h3f);
      host.acc(1'b1, 8'h03, 8'h00, v, q);
      host.acc(1'b1, 8'h04, 8'h00, v, q);
   endtask
   task automatic t_level;
      sy[2] = 1'b1;
      sw[0] = 1'b1;
      rd(8'h01, 8'h04);
      `CHK(irq_n, 1'b0)
      rd(8'h01, 8'h04);
      rd(8'h02, 8'h01);
      sy[2] = 1'b0;
      sw[0] = 1'b0;
      rd(8'h01, 8'h04);
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h01);
      `CHK(irq_n, 1'b1)
   endtask
   task automatic results;
      if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      resetn = 1'b0;
      sy = 6'h00;
      sw = 6'h00;
      repeat (12) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (2) @(negedge ref_clk);
      t_reset();
      t_event(8'h01, 6'h3f, 6'h00);
      t_event(8'h01, 6'h3f, 6'h00);
      t_event(8'h02, 6'h00, 6'h3f);
      t_mask();
      t_level();
      results();
   end
endmodule
`default_nettype wire
